// ---- hw/pdc_debug_ctrl.v ----
`timescale 1ns/1ps
`include "pdc_defs.vh"

module pdc_debug_ctrl #(
    parameter DATA_W = 16,
    parameter BANK_AW = 8
) (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Holding register access from the protocol handler
    input wire reg_req,
    input wire reg_wr,
    input wire [15:0] reg_addr,
    input wire [DATA_W-1:0] reg_wdata,
    output reg [DATA_W-1:0] reg_rdata,
    output reg reg_ack,
    // Interpreter issue handshake
    input wire issue_req,
    input wire [15:0] issue_pc,
    output reg issue_grant,
    input wire instr_done,
    // Interpreter access to the word bank
    input wire [BANK_AW-1:0] bank_addr,
    input wire bank_we,
    input wire [DATA_W-1:0] bank_wdata,
    output reg [DATA_W-1:0] bank_rdata
);

    localparam BANK_N = 1 << BANK_AW;

    reg dbg_en_r;
    reg step_r;
    reg run_bp_r;
    reg [15:0] bp_addr_r;
    reg [15:0] cur_pc_r;
    reg busy_r;
    reg step_flight_r;
    reg [DATA_W-1:0] bank_mem [0:BANK_N-1];

    reg dbg_en_nxt;
    reg step_nxt;
    reg run_bp_nxt;
    reg [15:0] bp_addr_nxt;
    reg busy_nxt;
    reg step_flight_nxt;
    reg grant_nxt;
    reg ack_nxt;
    reg [DATA_W-1:0] rdata_nxt;

    wire accept;
    wire host_wr;
    wire in_bank;
    wire [15:0] bank_off;
    wire [BANK_AW-1:0] host_bank_idx;
    wire bank_clash;
    wire take;
    wire bp_match;
    reg may_issue;
    reg bp_stop;

    assign in_bank = (reg_addr >= `PDC_ADDR_BANK_LO) &&
                     (reg_addr <= `PDC_ADDR_BANK_HI);
    assign bank_off = reg_addr - `PDC_ADDR_BANK_LO;
    assign host_bank_idx = bank_off[BANK_AW-1:0];
    // Interpreter write owns the bank port; a host bank write waits while bank_we is high
    assign bank_clash = reg_wr && in_bank && bank_we;
    assign accept = reg_req && !reg_ack && !bank_clash;
    assign host_wr = accept && reg_wr;

    // Issue slot free: no instruction in flight, no grant pending
    assign take = issue_req && !busy_r && !issue_grant;
    assign bp_match = (issue_pc == bp_addr_r); // RULE5

    // Mode decode on {debug, step, run-to-bp}; step has precedence
    always @* begin
        may_issue = 1'b0;
        bp_stop = 1'b0;
        case ({dbg_en_r, step_r, run_bp_r})
            3'h0, 3'h1, 3'h2, 3'h3: begin
                may_issue = 1'b1; // RULE4
            end
            3'h6, 3'h7: begin
                // One grant per written step; cleared at retirement
                may_issue = !step_flight_r; // RULE2
            end
            3'h5: begin
                may_issue = !bp_match; // RULE1
                bp_stop = bp_match; // RULE1
            end
            default: begin
                // Debug on, no request flag: hold current instruction
                may_issue = 1'b0; // RULE3
            end
        endcase
    end

    always @* begin
        dbg_en_nxt = dbg_en_r;
        step_nxt = step_r;
        run_bp_nxt = run_bp_r;
        bp_addr_nxt = bp_addr_r;
        busy_nxt = busy_r;
        step_flight_nxt = step_flight_r;
        grant_nxt = 1'b0;
        ack_nxt = accept;
        rdata_nxt = reg_rdata;

        // Instruction retirement
        if (instr_done && busy_r) begin
            busy_nxt = 1'b0;
            if (step_flight_r) begin
                step_nxt = 1'b0; // RULE2
                step_flight_nxt = 1'b0;
            end
        end

        // Breakpoint reached: drop to pause and await steps
        if (take && bp_stop) begin
            run_bp_nxt = 1'b0; // RULE1
        end

        if (take && may_issue) begin
            grant_nxt = 1'b1;
            busy_nxt = 1'b1;
            step_flight_nxt = dbg_en_r && step_r; // RULE2
        end

        // Host writes come last so a set beats a hardware clear
        if (host_wr) begin
            case (reg_addr)
                `PDC_ADDR_DBG_EN: begin
                    dbg_en_nxt = reg_wdata[`PDC_FLAG_BIT];
                end
                `PDC_ADDR_STEP: begin
                    step_nxt = reg_wdata[`PDC_FLAG_BIT];
                end
                `PDC_ADDR_RUN_BP: begin
                    run_bp_nxt = reg_wdata[`PDC_FLAG_BIT];
                end
                `PDC_ADDR_BP: begin
                    bp_addr_nxt = reg_wdata[15:0];
                end
                default: begin
                    bp_addr_nxt = bp_addr_r;
                end
            endcase
        end

        // Read mux; unmapped addresses read zero
        if (accept && !reg_wr) begin
            rdata_nxt = {DATA_W{1'b0}};
            if (in_bank) begin
                rdata_nxt = bank_mem[host_bank_idx];
            end else begin
                case (reg_addr)
                    `PDC_ADDR_CUR_PC: begin
                        rdata_nxt = cur_pc_r;
                    end
                    `PDC_ADDR_DBG_EN: begin
                        rdata_nxt[`PDC_FLAG_BIT] = dbg_en_r;
                    end
                    `PDC_ADDR_STEP: begin
                        rdata_nxt[`PDC_FLAG_BIT] = step_r;
                    end
                    `PDC_ADDR_RUN_BP: begin
                        rdata_nxt[`PDC_FLAG_BIT] = run_bp_r;
                    end
                    `PDC_ADDR_BP: begin
                        rdata_nxt = bp_addr_r;
                    end
                    default: begin
                        rdata_nxt = {DATA_W{1'b0}};
                    end
                endcase
            end
        end
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dbg_en_r <= `PDC_RST_FLAG;
            step_r <= `PDC_RST_FLAG;
            run_bp_r <= `PDC_RST_FLAG;
            bp_addr_r <= `PDC_RST_BP;
            cur_pc_r <= `PDC_RST_PC;
            busy_r <= 1'b0;
            step_flight_r <= 1'b0;
            issue_grant <= 1'b0;
            reg_ack <= 1'b0;
            reg_rdata <= {DATA_W{1'b0}};
        end else begin
            dbg_en_r <= dbg_en_nxt;
            step_r <= step_nxt;
            run_bp_r <= run_bp_nxt;
            bp_addr_r <= bp_addr_nxt;
            cur_pc_r <= issue_pc;
            busy_r <= busy_nxt;
            step_flight_r <= step_flight_nxt;
            issue_grant <= grant_nxt;
            reg_ack <= ack_nxt;
            reg_rdata <= rdata_nxt;
        end
    end

    // Bank storage; no reset, contents follow whoever writes
    always @(posedge mclk) begin
        if (bank_we) begin
            bank_mem[bank_addr] <= bank_wdata;
        end else if (host_wr && in_bank) begin
            bank_mem[host_bank_idx] <= reg_wdata;
        end
    end

    // Interpreter read port; one cycle from address to data
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            bank_rdata <= `PDC_RST_WORD;
        end else begin
            bank_rdata <= bank_mem[bank_addr];
        end
    end

endmodule // pdc_debug_ctrl

// ---- hw/pdc_defs.vh ----
// Summary of operation
// RULE1: Debug on, run-to-bp on, step off: run to breakpoint, then step mode.
// RULE2: Step mode: a step write of 1 runs one instruction, then self-clears.
// RULE3: Debug on with step and run-to-bp off holds the current instruction.
// RULE4: All flags off: the program runs freely, breakpoint address ignored.
// RULE5: Breakpoint compare precedes issue, so that instruction stays unrun.
`ifndef PDC_DEFS_VH
`define PDC_DEFS_VH

// Holding register addresses
`define PDC_ADDR_CUR_PC 16'h0497
`define PDC_ADDR_DBG_EN 16'h2710
`define PDC_ADDR_STEP 16'h2711
`define PDC_ADDR_RUN_BP 16'h2712
`define PDC_ADDR_BP 16'h2713
`define PDC_ADDR_BANK_LO 16'h2774
`define PDC_ADDR_BANK_HI 16'h2873

// Flag bit inside a flag register
`define PDC_FLAG_BIT 0

// Reset values
`define PDC_RST_FLAG 1'b0
`define PDC_RST_BP 16'h0000
`define PDC_RST_PC 16'h0000
`define PDC_RST_WORD 16'h0000

`endif

// ---- tb/pdc_debug_ctrl_monitor.sv ----
`timescale 1ns/1ps
module pdc_debug_ctrl_monitor #(
    parameter DATA_W = 16
) (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Host and interpreter
    input wire reg_req,
    input wire reg_wr,
    input wire [15:0] reg_addr,
    input wire [DATA_W-1:0] reg_wdata,
    input wire reg_ack,
    input wire issue_req,
    input wire [15:0] issue_pc,
    input wire issue_grant,
    input wire instr_done
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Shadows: a 0 here is exact, a 1 may be stale after a self-clear
    reg dbg_r, stp_r, rbp_r, busy_r;
    reg [15:0] bp_r;
    wire wr_take = reg_req && reg_wr && !reg_ack;
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            {dbg_r, stp_r, rbp_r, busy_r} <= 4'h0;
            bp_r <= 16'h0000;
        end else begin
            if (wr_take && reg_addr == 16'h2710) dbg_r <= reg_wdata[0];
            if (wr_take && reg_addr == 16'h2711) stp_r <= reg_wdata[0];
            if (wr_take && reg_addr == 16'h2712) rbp_r <= reg_wdata[0];
            if (wr_take && reg_addr == 16'h2713) bp_r <= reg_wdata[15:0];
            if (issue_grant) busy_r <= 1'b1;
            else if (instr_done) busy_r <= 1'b0;
        end
    end
    AST_GRANT_PULSE: assert property (issue_grant |=> !issue_grant)
        else $error("grant longer than one cycle");
    AST_DONE_GAP: assert property (instr_done |=> !issue_grant)
        else $error("grant too soon after done");
    AST_PAUSE: assert property (dbg_r && !stp_r && !rbp_r |=> !issue_grant)
        else $error("grant while paused");
    AST_BP_STOP: assert property (dbg_r && rbp_r && !stp_r && issue_req
        && issue_pc == bp_r |=> !issue_grant)
        else $error("breakpoint instruction issued");
    AST_FREE_RUN: assert property (!dbg_r && issue_req && !busy_r
        && !issue_grant |=> issue_grant)
        else $error("free run grant missing");
endmodule // pdc_debug_ctrl_monitor

bind pdc_debug_ctrl pdc_debug_ctrl_monitor #(.DATA_W(DATA_W)) u_mon (
    .mclk, .reset_n, .reg_req, .reg_wr, .reg_addr, .reg_wdata, .reg_ack,
    .issue_req, .issue_pc, .issue_grant, .instr_done);

// ---- tb/pdc_interp_model.sv ----
`timescale 1ns/1ps
module pdc_interp_model (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Issue handshake
    output wire issue_req,
    output reg [15:0] issue_pc,
    input wire issue_grant,
    output reg instr_done
);
    // Always wants work; each instruction retires the cycle after grant
    assign issue_req = reset_n;
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            issue_pc <= 16'h0000;
            instr_done <= 1'b0;
        end else begin
            instr_done <= issue_grant;
            if (instr_done) issue_pc <= issue_pc + 16'h0001;
        end
    end
endmodule // pdc_interp_model

// ---- tb/tb_plc_program_debug_control.sv ----
`timescale 1ns/1ps
module tb_plc_program_debug_control;
    reg mclk, reset_n, reg_req, reg_wr;
    reg [15:0] reg_addr, reg_wdata, q, p;
    wire [15:0] reg_rdata, pc;
    wire reg_ack, issue_req, issue_grant, instr_done;
    reg bank_we;
    reg [7:0] bank_addr;
    reg [15:0] bank_wdata;
    wire [15:0] bank_rdata;
    integer miscompares = 0, cmp_count = 0, i;
    pdc_debug_ctrl dut (.mclk(mclk), .reset_n(reset_n), .reg_req(reg_req),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .issue_req(issue_req),
        .issue_pc(pc), .issue_grant(issue_grant), .instr_done(instr_done),
        .bank_addr(bank_addr), .bank_we(bank_we), .bank_wdata(bank_wdata),
        .bank_rdata(bank_rdata));
    pdc_interp_model u_interp (.mclk(mclk), .reset_n(reset_n),
        .issue_req(issue_req), .issue_pc(pc), .issue_grant(issue_grant),
        .instr_done(instr_done));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task tally_and_finish; begin
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    end endtask
    task chk(input [15:0] g, input [15:0] e); begin
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    end endtask
    // Held through the edge that samples ack; data taken at that edge
    task acc(input w, input [15:0] a, input [15:0] d); integer k; begin
        reg_req <= 1'b1;
        reg_wr <= w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        for (k = 0; k < 20 && reg_ack !== 1'b1; k = k + 1) @(posedge mclk);
        if (reg_ack !== 1'b1) miscompares = miscompares + 1;
        q = reg_rdata;
        reg_req <= 1'b0;
        @(posedge mclk);
    end endtask
    task wt(input integer n); begin
        repeat (n) @(posedge mclk);
    end endtask
    initial begin
        wt(2000);
        miscompares = miscompares + 1;
        tally_and_finish;
    end
    initial begin
        reg_req = 1'b0;
        reg_wr = 1'b0;
        reset_n = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        bank_we = 1'b0;
        bank_addr = 8'h00;
        bank_wdata = 16'h0000;
        wt(12);
        reset_n <= 1'b1;
        wt(1);
        acc(0, 16'h2710, 16'h0000);
        chk(q, 16'h0000);
        acc(1, 16'h2713, 16'h0002);
        acc(0, 16'h2713, 16'h0000);
        chk(q, 16'h0002);
        wt(40);
        chk({15'h0000, pc > 16'h0006}, 16'h0001);
        $display("free run test done");
        acc(1, 16'h2710, 16'h0001);
        wt(10);
        p = pc;
        wt(20);
        acc(1, 16'h0497, 16'hFFFF);
        acc(0, 16'h0497, 16'h0000);
        chk(q, p);
        chk(pc, p);
        $display("pause test done");
        for (i = 0; i < 2; i = i + 1) begin
            p = p + 16'h0001;
            acc(1, 16'h2711, 16'h0001);
            wt(10);
            chk(pc, p);
            acc(0, 16'h2711, 16'h0000);
            chk(q, 16'h0000);
        end
        // Explicit clear so the monitor's step shadow is exact again
        acc(1, 16'h2711, 16'h0000);
        $display("step test done");
        p = p + 16'h0004;
        acc(1, 16'h2713, p);
        acc(1, 16'h2712, 16'h0001);
        wt(30);
        acc(0, 16'h0497, 16'h0000);
        chk(q, p);
        acc(0, 16'h2712, 16'h0000);
        chk(q, 16'h0000);
        acc(1, 16'h2711, 16'h0001);
        wt(10);
        chk(pc, p + 16'h0001);
        $display("breakpoint test done");
        acc(1, 16'h2779, 16'hA5A5);
        acc(0, 16'h2779, 16'h0000);
        chk(q, 16'hA5A5);
        bank_addr <= 8'h05;
        wt(2);
        chk(bank_rdata, 16'hA5A5);
        bank_addr <= 8'h06;
        bank_wdata <= 16'h1234;
        bank_we <= 1'b1;
        wt(1);
        bank_we <= 1'b0;
        acc(0, 16'h277A, 16'h0000);
        chk(q, 16'h1234);
        // Host write to a busy bank is held off, not lost
        bank_we <= 1'b1;
        fork
            acc(1, 16'h277A, 16'h5A5A);
            begin
                repeat (3) @(posedge mclk);
                bank_we <= 1'b0;
            end
        join
        acc(0, 16'h277A, 16'h0000);
        chk(q, 16'h5A5A);
        acc(0, 16'h1000, 16'h0000);
        chk(q, 16'h0000);
        acc(1, 16'h2710, 16'h0000);
        wt(30);
        chk({15'h0000, pc > p + 16'h0005}, 16'h0001);
        $display("bank and resume test done");
        tally_and_finish;
    end
endmodule // tb_plc_program_debug_control
